/* File: design/adcf_pkg.sv */
// types shared by the result formatter
package adcf_pkg;

  // result placement modes, in field order
  typedef enum logic [1:0] {
    ADCF_TRUNC8,
    ADCF_RIGHT,
    ADCF_LEFT,
    ADCF_LEFT_SIGNED
  } adcf_mode_t;

  // axi response codes
  typedef enum logic [1:0] {
    ADCF_RESP_OKAY   = 2'h0,
    ADCF_RESP_SLVERR = 2'h2
  } adcf_resp_t;

endpackage : adcf_pkg

/* File: design/adcf_regs.svh */
// register offsets, field positions, reset values and counts of the result formatter
`ifndef ADCF_REGS_SVH
`define ADCF_REGS_SVH

// ****************************************
// register indices and byte addresses
// ****************************************
`define ADCF_IDX_RESULT_HIGH  8'h3D
`define ADCF_IDX_RESULT_LOW   8'h3E
`define ADCF_IDX_CLOCK_REG    8'h3F
`define ADCF_ADDR_RESULT_HIGH 8'hF4
`define ADCF_ADDR_RESULT_LOW  8'hF8
`define ADCF_ADDR_CLOCK_REG   8'hFC

// ****************************************
// clock register fields and reset
// ****************************************
`define ADCF_PRESCALE_MSB 7
`define ADCF_PRESCALE_LSB 5
`define ADCF_SOURCE_BIT   4
`define ADCF_JUSTIFY_MSB  3
`define ADCF_JUSTIFY_LSB  2
`define ADCF_CLOCK_REG_RESET 8'h04
`define ADCF_RESULT_RESET    8'h00

// ****************************************
// divider terminal counts
// ****************************************
`define ADCF_DIV1_MAX  4'h0
`define ADCF_DIV2_MAX  4'h1
`define ADCF_DIV4_MAX  4'h3
`define ADCF_DIV8_MAX  4'h7
`define ADCF_DIV16_MAX 4'hF

`endif

/* File: design/adcf_top.sv */
// converter result formatter, read interlock and clock prescaler
`timescale 1ns/1ps
`include "adcf_regs.svh"

module adcf_top #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  // axi4-lite write address
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic [2:0]        s_axi_awprot_i,
  // axi4-lite write data
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  // axi4-lite write response
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  output logic [1:0]             s_axi_bresp_o,
  // axi4-lite read address
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic [2:0]        s_axi_arprot_i,
  // axi4-lite read data
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  // converter core
  input  wire logic              conv_done_i,
  input  wire logic [9:0]        conv_result_i,
  // clock sources, converter clock and result hold flag
  input  wire logic              crystal_clock_i,
  output logic                   conv_clk_tick_o,
  output logic                   result_held_o
);

  // ****************************************
  // elaboration checks
  // ****************************************
  generate
    if (ADDR_W < 8) begin : g_bad_addr
      $error("adcf_top: ADDR_W must be at least 8");
    end
  endgenerate

  // ****************************************
  // state
  // ****************************************
  logic [7:0]        converter_clock_register;
  logic [7:0]        next_converter_clock_register;
  logic [7:0]        result_high_byte;
  logic [7:0]        next_result_high_byte;
  logic [7:0]        result_low_byte;
  logic [7:0]        next_result_low_byte;
  logic              held;
  logic              next_held;
  logic              aw_full;
  logic              next_aw_full;
  logic [ADDR_W-1:0] aw_addr;
  logic [ADDR_W-1:0] next_aw_addr;
  logic              w_full;
  logic              next_w_full;
  logic [31:0]       w_data;
  logic [31:0]       next_w_data;
  logic [3:0]        w_strb;
  logic [3:0]        next_w_strb;
  logic              bvalid;
  logic              next_bvalid;
  logic [1:0]        bresp;
  logic [1:0]        next_bresp;
  logic              rvalid;
  logic              next_rvalid;
  logic [31:0]       rdata;
  logic [31:0]       next_rdata;
  logic [1:0]        rresp;
  logic [1:0]        next_rresp;
  logic              xtal_s1;
  logic              xtal_s2;
  logic              xtal_s3;
  logic [3:0]        div_cnt;
  logic [3:0]        next_div_cnt;
  logic [3:0]        div_max;
  logic [3:0]        next_div_max;
  logic              div_src_bus;
  logic              next_div_src_bus;
  logic              tick;
  logic              next_tick;

  // ****************************************
  // decoded fields
  // ****************************************
  adcf_pkg::adcf_mode_t justify_select;
  logic [2:0]           prescale_select;
  logic                 clock_source_select;
  logic                 wr_fire;
  logic                 rd_fire;
  logic                 src_tick;
  logic [3:0]           sel_max;
  logic [7:0]           fmt_high;
  logic [7:0]           fmt_low;

  // field views of the clock register
  assign justify_select      = adcf_pkg::adcf_mode_t'(
    converter_clock_register[`ADCF_JUSTIFY_MSB:`ADCF_JUSTIFY_LSB]);
  assign prescale_select     =
    converter_clock_register[`ADCF_PRESCALE_MSB:`ADCF_PRESCALE_LSB];
  assign clock_source_select = converter_clock_register[`ADCF_SOURCE_BIT];

  // ****************************************
  // result placement
  // ****************************************
  // map the ten-bit result into the two bytes
  always_comb begin
    fmt_high = 8'h00;
    fmt_low  = 8'h00;
    case (justify_select)
      adcf_pkg::ADCF_TRUNC8: begin
        fmt_low = conv_result_i[9:2];
      end
      adcf_pkg::ADCF_RIGHT: begin
        fmt_high = {6'h00, conv_result_i[9:8]};
        fmt_low  = conv_result_i[7:0];
      end
      adcf_pkg::ADCF_LEFT: begin
        fmt_high = conv_result_i[9:2];
        fmt_low  = {conv_result_i[1:0], 6'h00};
      end
      adcf_pkg::ADCF_LEFT_SIGNED: begin
        fmt_high = {~conv_result_i[9], conv_result_i[8:2]};
        fmt_low  = {conv_result_i[1:0], 6'h00};
      end
      default: begin
        fmt_high = 8'h00;
        fmt_low  = 8'h00;
      end
    endcase
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  // channel readies, combinational
  assign s_axi_awready_o = !aw_full && !bvalid;
  assign s_axi_wready_o  = !w_full && !bvalid;
  assign s_axi_arready_o = !rvalid;
  assign wr_fire         = aw_full && w_full && !bvalid;
  assign rd_fire         = s_axi_arvalid_i && !rvalid;

  // write path: hold address and data, then commit
  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full  = w_full;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_converter_clock_register = converter_clock_register;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata_i;
      next_w_strb = s_axi_wstrb_i;
    end
    if (wr_fire) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = adcf_pkg::ADCF_RESP_OKAY;
      case (aw_addr[7:0])
        `ADCF_ADDR_CLOCK_REG: begin
          if (w_strb[0]) begin
            next_converter_clock_register = {w_data[7:2], 2'h0};
          end
        end
        `ADCF_ADDR_RESULT_HIGH, `ADCF_ADDR_RESULT_LOW: begin
          next_bresp = adcf_pkg::ADCF_RESP_OKAY;
        end
        default: begin
          next_bresp = adcf_pkg::ADCF_RESP_SLVERR;
        end
      endcase
      if (ADDR_W > 8 && (aw_addr >> 8) != '0) begin
        next_bresp = adcf_pkg::ADCF_RESP_SLVERR;
        next_converter_clock_register = converter_clock_register;
      end
    end
    if (bvalid && s_axi_bready_i) begin
      next_bvalid = 1'b0;
    end
  end

  // read path: one beat answered the cycle after address
  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rresp  = adcf_pkg::ADCF_RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      case (s_axi_araddr_i[7:0])
        `ADCF_ADDR_RESULT_HIGH: next_rdata = {24'h00_0000, result_high_byte};
        `ADCF_ADDR_RESULT_LOW:  next_rdata = {24'h00_0000, result_low_byte};
        `ADCF_ADDR_CLOCK_REG:   next_rdata = {24'h00_0000, converter_clock_register};
        default:                next_rresp = adcf_pkg::ADCF_RESP_SLVERR;
      endcase
      if (ADDR_W > 8 && (s_axi_araddr_i >> 8) != '0) begin
        next_rdata = 32'h0000_0000;
        next_rresp = adcf_pkg::ADCF_RESP_SLVERR;
      end
    end
    if (rvalid && s_axi_rready_i) begin
      next_rvalid = 1'b0;
    end
  end

  // ****************************************
  // result bytes and read interlock
  // ****************************************
  logic rd_high;
  logic rd_low;
  assign rd_high = rd_fire && s_axi_araddr_i == ADDR_W'(`ADCF_ADDR_RESULT_HIGH);
  assign rd_low  = rd_fire && s_axi_araddr_i == ADDR_W'(`ADCF_ADDR_RESULT_LOW);

  // load on completion; outside ADCF_TRUNC8, freeze after high read
  always_comb begin
    next_result_high_byte = result_high_byte;
    next_result_low_byte  = result_low_byte;
    next_held             = held;
    if (justify_select == adcf_pkg::ADCF_TRUNC8) begin
      next_held = 1'b0;
      if (conv_done_i) begin
        next_result_low_byte = fmt_low;
      end
    end else begin
      if (conv_done_i && !held) begin
        next_result_high_byte = fmt_high;
        next_result_low_byte  = fmt_low;
      end
      if (rd_low) begin
        next_held = 1'b0;
      end
      if (rd_high) begin
        next_held = 1'b1;
      end
    end
  end

  assign result_held_o = held;

  // ****************************************
  // converter clock prescaler
  // ****************************************
  // terminal count for the programmed ratio
  always_comb begin
    case (prescale_select)
      3'h0:    sel_max = `ADCF_DIV1_MAX;
      3'h1:    sel_max = `ADCF_DIV2_MAX;
      3'h2:    sel_max = `ADCF_DIV4_MAX;
      3'h3:    sel_max = `ADCF_DIV8_MAX;
      default: sel_max = `ADCF_DIV16_MAX;
    endcase
  end

  // source edge: every bus cycle, or a crystal rise
  assign src_tick = div_src_bus ? 1'b1 : (xtal_s2 && !xtal_s3);

  // count source edges; new setting taken only at wrap
  always_comb begin
    next_div_cnt     = div_cnt;
    next_div_max     = div_max;
    next_div_src_bus = div_src_bus;
    next_tick        = 1'b0;
    if (src_tick) begin
      if (div_cnt >= div_max) begin
        next_div_cnt     = 4'h0;
        next_tick        = 1'b1;
        next_div_max     = sel_max;
        next_div_src_bus = clock_source_select;
      end else begin
        next_div_cnt = div_cnt + 4'h1;
      end
    end
  end

  assign conv_clk_tick_o = tick;

  // ****************************************
  // registers
  // ****************************************
  // crystal synchroniser, third stage for edge
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      xtal_s1 <= 1'b0;
      xtal_s2 <= 1'b0;
      xtal_s3 <= 1'b0;
    end else begin
      xtal_s1 <= crystal_clock_i;
      xtal_s2 <= xtal_s1;
      xtal_s3 <= xtal_s2;
    end
  end

  // all other state
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      converter_clock_register <= `ADCF_CLOCK_REG_RESET;
      result_high_byte         <= `ADCF_RESULT_RESET;
      result_low_byte          <= `ADCF_RESULT_RESET;
      held                     <= 1'b0;
      aw_full                  <= 1'b0;
      aw_addr                  <= '0;
      w_full                   <= 1'b0;
      w_data                   <= 32'h0000_0000;
      w_strb                   <= 4'h0;
      bvalid                   <= 1'b0;
      bresp                    <= 2'h0;
      rvalid                   <= 1'b0;
      rdata                    <= 32'h0000_0000;
      rresp                    <= 2'h0;
      div_cnt                  <= 4'h0;
      div_max                  <= `ADCF_DIV1_MAX;
      div_src_bus              <= 1'b0;
      tick                     <= 1'b0;
    end else begin
      converter_clock_register <= next_converter_clock_register;
      result_high_byte         <= next_result_high_byte;
      result_low_byte          <= next_result_low_byte;
      held                     <= next_held;
      aw_full                  <= next_aw_full;
      aw_addr                  <= next_aw_addr;
      w_full                   <= next_w_full;
      w_data                   <= next_w_data;
      w_strb                   <= next_w_strb;
      bvalid                   <= next_bvalid;
      bresp                    <= next_bresp;
      rvalid                   <= next_rvalid;
      rdata                    <= next_rdata;
      rresp                    <= next_rresp;
      div_cnt                  <= next_div_cnt;
      div_max                  <= next_div_max;
      div_src_bus              <= next_div_src_bus;
      tick                     <= next_tick;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o  = bresp;
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rdata_o  = rdata;
  assign s_axi_rresp_o  = rresp;

endmodule : adcf_top

/* File: dv/adcf_core_model.sv */
// converter core stand-in: completion pulses and the crystal pin
`timescale 1ns/1ps

module adcf_core_model (
  // clock
  input  wire logic mclk_i,
  // core outputs
  output logic       conv_done_o,
  output logic [9:0] conv_result_o,
  output logic       crystal_clock_o
);
  // free-running 31.25 MHz crystal, above 1 MHz; divide by 16 stays under 2 MHz
  initial crystal_clock_o = 1'b0;
  always #16 crystal_clock_o = ~crystal_clock_o;

  // idle state before the first conversion
  initial begin
    conv_done_o   = 1'b0;
    conv_result_o = 10'h155;
  end

  // one-cycle completion, result scrambled outside it
  task automatic conv(input logic [9:0] v);
    conv_done_o   <= 1'b1;
    conv_result_o <= v;
    @(posedge mclk_i);
    conv_done_o   <= 1'b0;
    conv_result_o <= ~v;
  endtask : conv
endmodule : adcf_core_model

/* File: dv/adcf_props.sv */
// port assertions for the result formatter
`timescale 1ns/1ps
`include "adcf_regs.svh"

module adcf_props #(
  parameter int ADDR_W = 8
) (
  // watched ports
  input wire logic              mclk_i,
  input wire logic              rst_n_i,
  input wire logic              s_axi_awvalid_i,
  input wire logic              s_axi_awready_o,
  input wire logic              s_axi_wvalid_i,
  input wire logic              s_axi_wready_o,
  input wire logic              s_axi_bvalid_o,
  input wire logic              s_axi_bready_i,
  input wire logic [1:0]        s_axi_bresp_o,
  input wire logic              s_axi_arvalid_i,
  input wire logic              s_axi_arready_o,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic              s_axi_rvalid_o,
  input wire logic              s_axi_rready_i,
  input wire logic [31:0]       s_axi_rdata_o,
  input wire logic [1:0]        s_axi_rresp_o,
  input wire logic              conv_clk_tick_o,
  input wire logic              result_held_o
);
  // ****************************************
  // bus timing and interlock
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic ar_go = s_axi_arvalid_i && s_axi_arready_o;

  write_resp_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write answer late");
  read_resp_a: assert property (ar_go |=> s_axi_rvalid_o) else $error("read answer late");
  bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
    && $stable(s_axi_bresp_o)) else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
    && $stable(s_axi_rdata_o)) else $error("read answer dropped");
  upper_zero_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  unmapped_err_a: assert property (ar_go && s_axi_araddr_i[1:0] != 2'h0 |=>
    s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0) else $error("unmapped read not refused");
  hold_clear_a: assert property (ar_go && s_axi_araddr_i == ADDR_W'(`ADCF_ADDR_RESULT_LOW)
    |=> !result_held_o) else $error("low read left hold set");
  hold_cause_a: assert property ($rose(result_held_o) |->
    $past(ar_go) && $past(s_axi_araddr_i) == ADDR_W'(`ADCF_ADDR_RESULT_HIGH))
    else $error("hold set without high read");

  // main scenarios
  held_c: cover property ($rose(result_held_o));
  tick_c: cover property (conv_clk_tick_o);
  err_c: cover property (ar_go && s_axi_araddr_i[1:0] != 2'h0);
endmodule : adcf_props

bind adcf_top adcf_props #(.ADDR_W(ADDR_W)) u_props (.mclk_i, .rst_n_i, .s_axi_awvalid_i,
  .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_araddr_i, .s_axi_rvalid_o,
  .s_axi_rready_i, .s_axi_rdata_o, .s_axi_rresp_o, .conv_clk_tick_o, .result_held_o);

/* File: dv/adcf_top_tb.sv */
// self-checking bench for the result formatter and prescaler
`timescale 1ns/1ps
`include "adcf_regs.svh"

module adcf_top_tb;
  // bench signals
  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             awv = 1'b0, wv = 1'b0, bb = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [7:0]       awa = 8'h00, ara = 8'h00;
  logic [31:0]      wd = 32'h0;
  wire logic        awr, wrdy, bv, arr, rv, done, xtal, tick, held;
  wire logic [1:0]  brsp, rrsp;
  wire logic [31:0] rdat;
  wire logic [9:0]  res;
  int               err_total = 0;
  int               checks = 0;

  always #2 clk = ~clk;

  adcf_top dut (.mclk_i(clk), .rst_n_i(rst_n), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_awaddr_i(awa), .s_axi_awprot_i(3'h0), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_bvalid_o(bv), .s_axi_bready_i(bb),
    .s_axi_bresp_o(brsp), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara),
    .s_axi_arprot_i(3'h0), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .s_axi_rdata_o(rdat),
    .s_axi_rresp_o(rrsp), .conv_done_i(done), .conv_result_i(res), .crystal_clock_i(xtal),
    .conv_clk_tick_o(tick), .result_held_o(held));
  adcf_core_model core (.mclk_i(clk), .conv_done_o(done), .conv_result_o(res),
    .crystal_clock_o(xtal));

  // verdict and end of run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  task automatic ck(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : ck

  // a spent wait ends the run
  task automatic lim(input logic g);
    if (!g) begin
      err_total++;
      end_sim;
    end
  endtask : lim

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int   n;
    logic ta, tw, g;
    awv <= 1'b1;
    wv  <= 1'b1;
    awa <= a;
    wd  <= d;
    ta = 1'b0;
    tw = 1'b0;
    g  = 1'b0;
    for (n = 0; n < 40 && !(ta && tw); n++) begin
      @(negedge clk);
      ta = ta || (awv && awr);
      tw = tw || (wv && wrdy);
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    lim(ta && tw);
    bb <= 1'b1;
    for (n = 0; n < 40 && !g; n++) begin
      @(negedge clk);
      g = bv;
      r = brsp;
      @(posedge clk);
    end
    bb <= 1'b0;
    lim(g);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic g;
    arv <= 1'b1;
    ara <= a;
    g = 1'b0;
    for (n = 0; n < 40 && !g; n++) begin
      @(negedge clk);
      g = arr;
      @(posedge clk);
    end
    lim(g);
    arv <= 1'b0;
    rr  <= 1'b1;
    g = 1'b0;
    for (n = 0; n < 40 && !g; n++) begin
      @(negedge clk);
      g = rv;
      d = rdat;
      r = rrsp;
      @(posedge clk);
    end
    rr <= 1'b0;
    lim(g);
  endtask : rd

  // expected high and low byte for a mode; h is the standing high byte
  function automatic logic [15:0] fmt(input logic [1:0] m, input logic [9:0] v,
                                      input logic [7:0] h);
    case (m)
      2'h0: fmt = {h, v[9:2]};
      2'h1: fmt = {6'h00, v};
      2'h2: fmt = {v, 6'h00};
      default: fmt = {~v[9], v[8:0], 6'h00};
    endcase
  endfunction : fmt

  // counts converter ticks over a window
  task automatic cnt(input int w, output int t);
    t = 0;
    repeat (w) begin
      @(negedge clk);
      t += int'(tick);
    end
    @(posedge clk);
  endtask : cnt

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [15:0] e;
    logic [9:0]  v;
    logic [7:0]  h;
    int          m, t;
    h = 8'h00;
    void'($urandom(2));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`ADCF_ADDR_CLOCK_REG, d, r);
    ck(d, 32'h4);
    rd(`ADCF_ADDR_RESULT_LOW, d, r);
    ck(d, 32'h0);
    rd(8'hF5, d, r);
    ck({30'h0, r}, 32'h2);
    for (m = 0; m < 4; m++) begin
      wr(`ADCF_ADDR_CLOCK_REG, {26'h1, m[1:0], 2'h0}, r);
      v = 10'($urandom);
      core.conv(v);
      e = fmt(m[1:0], v, h);
      rd(`ADCF_ADDR_RESULT_HIGH, d, r);
      ck(d, {24'h0, e[15:8]});
      ck({31'h0, held}, {31'h0, m != 0});
      core.conv(~v);
      if (m == 0) e = fmt(2'h0, ~v, h);
      rd(`ADCF_ADDR_RESULT_LOW, d, r);
      ck(d, {24'h0, e[7:0]});
      core.conv(~v);
      e = fmt(m[1:0], ~v, e[15:8]);
      rd(`ADCF_ADDR_RESULT_HIGH, d, r);
      ck(d, {24'h0, e[15:8]});
      rd(`ADCF_ADDR_RESULT_LOW, d, r);
      h = e[15:8];
    end
    wr(`ADCF_ADDR_RESULT_HIGH, 32'hFF, r);
    ck({30'h0, r}, 32'h0);
    rd(`ADCF_ADDR_RESULT_HIGH, d, r);
    ck(d, {24'h0, h});
    for (m = 0; m < 8; m++) begin
      wr(`ADCF_ADDR_CLOCK_REG, {24'h0, m[2:0], 5'h14}, r);
      repeat (40) @(posedge clk);
      cnt(64, t);
      ck(32'(t), 32'(64 >> (m > 3 ? 4 : m)));
    end
    wr(`ADCF_ADDR_CLOCK_REG, 32'h4, r);
    repeat (40) @(posedge clk);
    cnt(240, t);
    ck({31'h0, t >= 29 && t <= 31}, 32'h1);
    // crystal divided by 16 keeps the converter clock inside its range
    wr(`ADCF_ADDR_CLOCK_REG, 32'h84, r);
    repeat (40) @(posedge clk);
    cnt(1280, t);
    ck({31'h0, t >= 9 && t <= 11}, 32'h1);
    end_sim;
  end
endmodule : adcf_top_tb
